// file: hw/fpes_seq.v
// fpes_seq.v: program/erase sequencer with muxed-address programming port
// assumes: all pins synchronous to core_clk_i; data pins resolved outside
`timescale 1ns/1ns
`default_nettype none
`include "fpes_regs.vh"
module fpes_seq #(
    parameter       AW        = 19,
    parameter [7:0] MFR_CODE  = 8'hA5, // arbitrary value
    parameter [7:0] DEV_CODE  = 8'h5A, // arbitrary value
    parameter       PROG_CYC  = `FPES_PROG_CYC
) (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire        ce_i,
    // interface select and protection
    input  wire        interface_select_i,
    input  wire        top_sector_protect_n_i,
    input  wire        other_sector_protect_n_i,
    input  wire [7:0]  sector_write_lock_i,
    input  wire        vpp_ok_i,
    // muxed programming port
    input  wire        row_col_sel_i,
    input  wire [10:0] mux_addr_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    // data pins
    input  wire [7:0]  data_pins_i,
    output reg  [7:0]  data_pins_o,
    output wire [7:0]  data_pins_oe_n_o,
    // open-drain ready/busy
    output wire        rdy_busy_o,
    output wire        rdy_busy_oe_n_o,
    // status view
    output wire [7:0]  operation_status_o
);
    ////////////////////////////////////////////////////////////////////////
    localparam [5:0] S_IDLE  = 6'h01;
    localparam [5:0] S_ESET  = 6'h02;
    localparam [5:0] S_PSET  = 6'h04;
    localparam [5:0] S_PROG  = 6'h08;
    localparam [5:0] S_VRFY  = 6'h10;
    localparam [5:0] S_ERASE = 6'h20;

    localparam [1:0] M_ARRAY  = 2'h0;
    localparam [1:0] M_STATUS = 2'h1;
    localparam [1:0] M_ID     = 2'h2;

    wire [AW-1:0] addr;
    reg  [5:0]    st_q;
    reg  [1:0]    mode_q;
    reg           we_q;
    reg  [7:0]    stat_q;
    reg  [AW-1:0] op_addr_q;
    reg  [AW-1:0] end_addr_q;
    reg  [7:0]    op_data_q;
    reg  [7:0]    old_q;
    reg           sub_q;
    reg  [15:0]   cnt_q;
    reg           mem_we;
    reg  [7:0]    mem_wdata;
    wire [7:0]    rdata;

    // muxed mode only with interface select high
    wire mux_en   = interface_select_i;
    wire busy     = (st_q == S_PROG) || (st_q == S_VRFY) || (st_q == S_ERASE);
    // write cycle is we low with oe high
    wire wr_fall  = mux_en && we_q && !we_n_i && oe_n_i;

    // sector 7 holds the four sub-sectors
    function blocked;
        input [AW-1:0] a;
        begin
            if (a[18:16] == 3'h7)
                blocked = sector_write_lock_i[7] || !top_sector_protect_n_i;
            else
                blocked = sector_write_lock_i[a[18:16]] || !other_sector_protect_n_i;
        end
    endfunction

    // sub-sector bounds 16k, 8k, 8k, 32k
    function [AW-1:0] sub_base;
        input [AW-1:0] a;
        begin
            if (a[15:14] == 2'h0)
                sub_base = {a[18:16], 16'h0000};
            else if (a[15:13] == 3'h2)
                sub_base = {a[18:16], 16'h4000};
            else if (a[15:13] == 3'h3)
                sub_base = {a[18:16], 16'h6000};
            else
                sub_base = {a[18:16], 16'h8000};
        end
    endfunction

    function [AW-1:0] sub_last;
        input [AW-1:0] a;
        begin
            if (a[15:14] == 2'h0)
                sub_last = {a[18:16], 16'h3FFF};
            else if (a[15:13] == 3'h2)
                sub_last = {a[18:16], 16'h5FFF};
            else if (a[15:13] == 3'h3)
                sub_last = {a[18:16], 16'h7FFF};
            else
                sub_last = {a[18:16], 16'hFFFF};
        end
    endfunction

    fpes_addr_latch u_addr (
        .core_clk_i    (core_clk_i),
        .rstn_i        (rstn_i),
        .ce_i          (ce_i),
        .row_col_sel_i (row_col_sel_i),
        .mux_addr_i    (mux_addr_i),
        .addr_o        (addr)
    );

    fpes_mem #(.AW(AW)) u_mem (
        .core_clk_i (core_clk_i),
        .ce_i       (ce_i),
        .we_i       (mem_we),
        .waddr_i    (op_addr_q),
        .wdata_i    (mem_wdata),
        .raddr_i    (busy ? op_addr_q : addr),
        .rdata_o    (rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always @*
    begin
        mem_we    = 1'b0;
        mem_wdata = 8'hFF;
        if (st_q == S_ERASE)
            mem_we = 1'b1;
        else if (st_q == S_PROG && cnt_q == 16'h0000)
        begin
            mem_we    = 1'b1;
            mem_wdata = old_q & op_data_q;
        end
    end

    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q       <= S_IDLE;
            mode_q     <= M_ARRAY;
            we_q       <= 1'b1;
            stat_q     <= `FPES_ST_RESET;
            op_addr_q  <= {AW{1'b0}};
            end_addr_q <= {AW{1'b0}};
            op_data_q  <= 8'hFF;
            old_q      <= 8'hFF;
            sub_q      <= 1'b0;
            cnt_q      <= 16'h0000;
        end
        else if (ce_i)
        begin
            we_q <= we_n_i;
            case (st_q)
                S_IDLE:
                begin
                    if (wr_fall)
                    begin
                        case (data_pins_i)
                            `FPES_CMD_READ_ARRAY:  mode_q <= M_ARRAY;
                            `FPES_CMD_ID_ENTRY:    mode_q <= M_ID;
                            `FPES_CMD_READ_STATUS: mode_q <= M_STATUS;
                            `FPES_CMD_CLEAR_STATUS:
                            begin
                                stat_q <= `FPES_ST_RESET;
                                mode_q <= M_ARRAY;
                            end
                            `FPES_CMD_ERASE_MAIN, `FPES_CMD_ERASE_SUB:
                            begin
                                sub_q  <= (data_pins_i == `FPES_CMD_ERASE_SUB);
                                st_q   <= S_ESET;
                                mode_q <= M_STATUS;
                            end
                            `FPES_CMD_PROG_A, `FPES_CMD_PROG_B:
                            begin
                                st_q   <= S_PSET;
                                mode_q <= M_STATUS;
                            end
                            default: mode_q <= mode_q;
                        endcase
                    end
                end
                S_ESET:
                begin
                    if (wr_fall)
                    begin
                        st_q <= S_IDLE;
                        if (data_pins_i != `FPES_CMD_CONFIRM)
                        begin
                            stat_q[`FPES_ST_ERASE] <= 1'b1;
                            stat_q[`FPES_ST_PROG]  <= 1'b1;
                        end
                        // lock or protect pin blocks erase
                        else if (blocked(addr))
                        begin
                            stat_q[`FPES_ST_ERASE]   <= 1'b1;
                            stat_q[`FPES_ST_PROTECT] <= 1'b1;
                        end
                        else if (!vpp_ok_i)
                        begin
                            stat_q[`FPES_ST_ERASE] <= 1'b1;
                            stat_q[`FPES_ST_VPP]   <= 1'b1;
                        end
                        else
                        begin
                            // main code spans whole 64k sector
                            if (sub_q && addr[18:16] == 3'h7)
                            begin
                                op_addr_q  <= sub_base(addr);
                                end_addr_q <= sub_last(addr);
                            end
                            else
                            begin
                                op_addr_q  <= {addr[18:16], 16'h0000};
                                end_addr_q <= {addr[18:16], 16'hFFFF};
                            end
                            st_q                 <= S_ERASE;
                            stat_q[`FPES_ST_READY] <= 1'b0;
                        end
                    end
                end
                S_PSET:
                begin
                    if (wr_fall)
                    begin
                        st_q <= S_IDLE;
                        // lock or protect pin blocks program
                        if (blocked(addr))
                        begin
                            stat_q[`FPES_ST_PROG]    <= 1'b1;
                            stat_q[`FPES_ST_PROTECT] <= 1'b1;
                        end
                        else if (!vpp_ok_i)
                        begin
                            stat_q[`FPES_ST_PROG] <= 1'b1;
                            stat_q[`FPES_ST_VPP]  <= 1'b1;
                        end
                        else
                        begin
                            // address and data on second cycle
                            op_addr_q              <= addr;
                            op_data_q              <= data_pins_i;
                            cnt_q                  <= PROG_CYC[15:0];
                            st_q                   <= S_PROG;
                            stat_q[`FPES_ST_READY] <= 1'b0;
                        end
                    end
                end
                S_PROG:
                begin
                    if (cnt_q == PROG_CYC[15:0])
                        old_q <= rdata;
                    if (cnt_q == 16'h0000)
                    begin
                        // one settling edge so verify sees the byte just written
                        cnt_q <= 16'h0001;
                        st_q  <= S_VRFY;
                    end
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                S_VRFY:
                begin
                    // read register lags the write by one edge
                    if (cnt_q != 16'h0000)
                        cnt_q <= cnt_q - 16'h0001;
                    else
                    begin
                        // only zeros left at zero count
                        if ((~op_data_q & rdata) != 8'h00 || !vpp_ok_i)
                            stat_q[`FPES_ST_PROG] <= 1'b1;
                        if (!vpp_ok_i)
                            stat_q[`FPES_ST_VPP] <= 1'b1;
                        stat_q[`FPES_ST_READY] <= 1'b1;
                        st_q                   <= S_IDLE;
                    end
                end
                S_ERASE:
                begin
                    if (op_addr_q == end_addr_q)
                    begin
                        if (!vpp_ok_i)
                        begin
                            stat_q[`FPES_ST_ERASE] <= 1'b1;
                            stat_q[`FPES_ST_VPP]   <= 1'b1;
                        end
                        stat_q[`FPES_ST_READY] <= 1'b1;
                        st_q                   <= S_IDLE;
                    end
                    else
                        op_addr_q <= op_addr_q + {{(AW-1){1'b0}}, 1'b1};
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bits 6, 2 and 0 forced low
    assign operation_status_o = {stat_q[7], 1'b0, stat_q[5:3], 1'b0, stat_q[1], 1'b0};

    // output data are registered; status and id one cycle after the address settles, array data two
    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            data_pins_o <= 8'h00;
        else if (ce_i)
        begin
            if (mode_q == M_STATUS || busy)
                data_pins_o <= operation_status_o;
            else if (mode_q == M_ID)
                data_pins_o <= (addr == `FPES_ID_MFR_ADDR) ? MFR_CODE :
                               (addr == `FPES_ID_DEV_ADDR) ? DEV_CODE : 8'h00;
            else
                data_pins_o <= rdata;
        end
    end

    // drive only with output strobe low
    assign data_pins_oe_n_o = {8{!(mux_en && !oe_n_i && we_n_i)}};
    assign rdy_busy_o      = 1'b0;
    assign rdy_busy_oe_n_o = !busy;
endmodule // fpes_seq
`default_nettype wire

// file: hw/fpes_regs.vh
// fpes_regs.vh: command codes, status bit positions and timing counts
// assumes: included by the sequencer design files, definitions only
`ifndef FPES_REGS_VH
`define FPES_REGS_VH

// command codes
`define FPES_CMD_READ_ARRAY   8'hFF
`define FPES_CMD_ERASE_MAIN   8'h20
`define FPES_CMD_ERASE_SUB    8'h21
`define FPES_CMD_PROG_A       8'h40
`define FPES_CMD_PROG_B       8'h10
`define FPES_CMD_ID_ENTRY     8'h90
`define FPES_CMD_READ_STATUS  8'h70
`define FPES_CMD_CLEAR_STATUS 8'h50
`define FPES_CMD_CONFIRM      8'hD0

// operation_status bit positions
`define FPES_ST_READY    7
`define FPES_ST_ERASE    5
`define FPES_ST_PROG     4
`define FPES_ST_VPP      3
`define FPES_ST_PROTECT  1
`define FPES_ST_RESET    8'h80

// identification addresses
`define FPES_ID_MFR_ADDR 19'h00000
`define FPES_ID_DEV_ADDR 19'h00001

// timing: times in ns, clock period in ns, program count derived
`define FPES_CLK_NS       50
`define FPES_PROG_NS      30000
`define FPES_PROG_CYC     ((`FPES_PROG_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS)
`define FPES_ERASE_CYC    2

`endif

// file: hw/fpes_mem.v
// fpes_mem.v: flash array model, one byte per address, registered read
// assumes: single clock; erase fill is done by the caller one byte per cycle
`timescale 1ns/1ns
`default_nettype none
module fpes_mem #(
    parameter AW = 19
) (
    // clock
    input  wire          core_clk_i,
    input  wire          ce_i,
    // write port
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [7:0]    wdata_i,
    // read port
    input  wire [AW-1:0] raddr_i,
    output reg  [7:0]    rdata_o
);
    reg [7:0] mem_q [0:(1<<AW)-1];

    always @(posedge core_clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
                mem_q[waddr_i] <= wdata_i;
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule // fpes_mem
`default_nettype wire

// file: hw/fpes_addr_latch.v
// fpes_addr_latch.v: row/column address capture from the muxed address pins
// assumes: pins synchronous to core_clk_i; edges found by compare with last sample
`timescale 1ns/1ns
`default_nettype none
module fpes_addr_latch (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire        ce_i,
    // pins
    input  wire        row_col_sel_i,
    input  wire [10:0] mux_addr_i,
    // latched address
    output wire [18:0] addr_o
);
    reg        rc_q;
    reg [10:0] row_q;
    reg [7:0]  col_q;

    always @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rc_q  <= 1'b1;
            row_q <= 11'h000;
            col_q <= 8'h00;
        end
        else if (ce_i)
        begin
            rc_q <= row_col_sel_i;
            if (rc_q && !row_col_sel_i)
                row_q <= mux_addr_i;
            if (!rc_q && row_col_sel_i)
                col_q <= mux_addr_i[7:0];
        end
    end

    assign addr_o = {col_q, row_q};
endmodule // fpes_addr_latch
`default_nettype wire

// file: testbench/fpes_seq_props.sv
// fpes_seq_props.sv: port-level checks for the program/erase sequencer
// assumes: bound to fpes_seq; one clock, asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module fpes_seq_props (
    // clock and reset
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    // strobes
    input wire logic       interface_select_i,
    input wire logic       oe_n_i,
    input wire logic       we_n_i,
    // outputs watched
    input wire logic [7:0] data_pins_oe_n_o,
    input wire logic       rdy_busy_oe_n_o,
    input wire logic [7:0] operation_status_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic [7:0] st = operation_status_o;
    ////////////////////////////////////////////////////////////
    property p_float; oe_n_i |-> data_pins_oe_n_o == 8'hFF; endproperty
    a_float: assert property (p_float) else $error("data pins driven with strobe high");
    property p_drive; interface_select_i && !oe_n_i && we_n_i |-> data_pins_oe_n_o == 8'h00;
    endproperty
    a_drive: assert property (p_drive) else $error("data pins not driven on read");
    property p_hub; !interface_select_i |-> data_pins_oe_n_o == 8'hFF; endproperty
    a_hub: assert property (p_hub) else $error("data pins driven in hub mode");
    property p_zero; st[6] == 1'b0 && st[2] == 1'b0 && st[0] == 1'b0; endproperty
    a_zero: assert property (p_zero) else $error("fixed status bits not zero");
    // a busy phase lasts at least three cycles
    property p_hold; $fell(st[7]) |-> !st[7] [*3]; endproperty
    a_hold: assert property (p_hold) else $error("busy phase too short");
    property p_cause; $fell(st[7]) |-> !$past(we_n_i) || !$past(we_n_i, 2) || !$past(we_n_i, 3);
    endproperty
    a_cause: assert property (p_cause) else $error("busy without a write");
    property p_pin; rdy_busy_oe_n_o == st[7]; endproperty
    a_pin: assert property (p_pin) else $error("busy pin and ready bit disagree");
    property p_clr; $fell(st[5]) |-> !$past(we_n_i) || !$past(we_n_i, 2); endproperty
    a_clr: assert property (p_clr) else $error("erase error cleared without a write");
    property p_vpp; $rose(st[3]) |-> st[5] || st[4]; endproperty
    a_vpp: assert property (p_vpp) else $error("supply flag without an error");
    property p_prot; $rose(st[1]) |-> st[5] || st[4]; endproperty
    a_prot: assert property (p_prot) else $error("protect flag without an error");
    c_busy: cover property ($fell(st[7]));
    c_both: cover property (st[5] && st[4]);
    c_read: cover property (data_pins_oe_n_o == 8'h00);
endmodule // fpes_seq_props
bind fpes_seq fpes_seq_props u_fpes_seq_props (
    .core_clk_i        (core_clk_i),
    .rstn_i            (rstn_i),
    .interface_select_i(interface_select_i),
    .oe_n_i            (oe_n_i),
    .we_n_i            (we_n_i),
    .data_pins_oe_n_o  (data_pins_oe_n_o),
    .rdy_busy_oe_n_o   (rdy_busy_oe_n_o),
    .operation_status_o(operation_status_o)
);
`default_nettype wire

// file: testbench/fpes_host.sv
// fpes_host.sv: factory programmer model on the muxed-address port
// assumes: pins change at the falling edge; device outputs are registered
`timescale 1ns/1ns
`default_nettype none
module fpes_host (
    // clock
    input  wire logic        core_clk_i,
    // device side of the data pins
    input  wire logic [7:0]  dev_q_i,
    input  wire logic [7:0]  dev_oe_n_i,
    // strobes, address and resolved data
    output var  logic        row_col_sel_o,
    output var  logic [10:0] mux_addr_o,
    output var  logic        oe_n_o,
    output var  logic        we_n_o,
    output wire logic [7:0]  bus_o
);
    logic       drv = 1'b0;
    logic [7:0] dout = 8'h00;
    // released lines show the inverse, so a stale byte never passes
    assign bus_o = (dev_oe_n_i == 8'h00) ? dev_q_i : (drv ? dout : ~dout);
    initial
    begin
        row_col_sel_o = 1'b1;
        mux_addr_o = 11'h000;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
    end
    task automatic seta(input logic [18:0] a);
    begin
        @(negedge core_clk_i);
        mux_addr_o = a[10:0];
        row_col_sel_o = 1'b0;
        @(negedge core_clk_i);
        mux_addr_o = {3'h0, a[18:11]};
        row_col_sel_o = 1'b1;
    end
    endtask
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
    begin
        seta(a);
        dout = d;
        drv = 1'b1;
        @(negedge core_clk_i);
        we_n_o = 1'b0;
        repeat (2) @(negedge core_clk_i);
        we_n_o = 1'b1;
        @(negedge core_clk_i);
        drv = 1'b0;
    end
    endtask
    task automatic rd(input logic [18:0] a, output logic [7:0] d);
    begin
        seta(a);
        @(negedge core_clk_i);
        oe_n_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
        d = bus_o;
        oe_n_o = 1'b1;
    end
    endtask
endmodule // fpes_host
`default_nettype wire

// file: testbench/fpes_seq_tb_top.sv
// fpes_seq_tb_top.sv: bench for the sequencer through its muxed port
// assumes: fpes_host drives the pins; short program count for speed
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module fpes_seq_tb_top;
    localparam logic [7:0] MFR = 8'h3C; // arbitrary value
    localparam logic [7:0] DEV = 8'hC3; // arbitrary value
    logic        clk = 1'b0;
    logic        rstn, sel, tsp_n, osp_n, vpp, saw;
    logic [7:0]  lock, d;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    wire logic        rc, oe_n, we_n, rbo, rb_oe_n;
    wire logic [10:0] ma;
    wire logic [7:0]  q, qoe_n, bus, st;
    always #25 clk = ~clk;
    fpes_seq #(.PROG_CYC(4), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_fpes_seq (
        .core_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .interface_select_i(sel),
        .top_sector_protect_n_i(tsp_n), .other_sector_protect_n_i(osp_n),
        .sector_write_lock_i(lock), .vpp_ok_i(vpp), .row_col_sel_i(rc), .mux_addr_i(ma),
        .oe_n_i(oe_n), .we_n_i(we_n), .data_pins_i(bus), .data_pins_o(q),
        .data_pins_oe_n_o(qoe_n), .rdy_busy_o(rbo), .rdy_busy_oe_n_o(rb_oe_n),
        .operation_status_o(st));
    fpes_host u_fpes_host (.core_clk_i(clk), .dev_q_i(q), .dev_oe_n_i(qoe_n),
        .row_col_sel_o(rc), .mux_addr_o(ma), .oe_n_o(oe_n), .we_n_o(we_n), .bus_o(bus));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
    begin
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // setup cycle always at 19'h20000 (sector 2), so only the second address may count
    task automatic op(input logic [18:0] a, input logic [7:0] c, input logic [7:0] x);
    begin
        u_fpes_host.wr(19'h20000, c);
        u_fpes_host.wr(a, x);
    end
    endtask
    task automatic waitr();
        int i;
    begin
        i = 0;
        while (st[7] !== 1'b1 && i < 70000)
        begin
            @(negedge clk);
            i++;
        end
    end
    endtask
    task automatic rs(input logic [7:0] e);
    begin
        u_fpes_host.rd(19'h00000, d);
        `CHK("status", e, d)
    end
    endtask
    task automatic clr();
    begin
        u_fpes_host.wr(19'h00000, 8'h50);
        `CHK("cleared", 8'h80, st)
    end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (!rb_oe_n)
            saw = 1'b1;
        if (cyc == 90000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0; sel = 1'b1; tsp_n = 1'b1; osp_n = 1'b1; vpp = 1'b1;
        lock = 8'h00; saw = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        `CHK("reset status", 8'h80, st)
        `CHK("pin enable", 8'hFF, qoe_n)
        u_fpes_host.wr(19'h00000, 8'h90);
        u_fpes_host.rd(19'h00000, d);
        `CHK("maker id", MFR, d)
        u_fpes_host.rd(19'h00001, d);
        `CHK("device id", DEV, d)
        u_fpes_host.wr(19'h00000, 8'h70);
        u_fpes_host.rd(19'h12345, d);
        `CHK("status mode", 8'h80, d)
        lock = 8'h01;
        op(19'h00010, 8'h40, 8'h00);
        rs(8'h92);
        clr();
        lock = 8'h00;
        op(19'h10000, 8'h20, 8'h33);
        rs(8'hB0);
        clr();
        tsp_n = 1'b0;
        op(19'h70000, 8'h20, 8'hD0);
        rs(8'hA2);
        tsp_n = 1'b1;
        clr();
        osp_n = 1'b0;
        op(19'h30000, 8'h40, 8'h00);
        rs(8'h92);
        osp_n = 1'b1;
        clr();
        vpp = 1'b0;
        op(19'h00020, 8'h10, 8'h00);
        rs(8'h98);
        vpp = 1'b1;
        clr();
        saw = 1'b0;
        op(19'h20005, 8'h10, 8'h00);
        waitr();
        rs(8'h80);
        `CHK("busy pin", 1'b1, saw)
        `CHK("busy pin level", 1'b0, rbo)
        op(19'h20005, 8'h40, 8'hFF);
        waitr();
        rs(8'h80);
        u_fpes_host.wr(19'h00000, 8'hFF);
        u_fpes_host.rd(19'h20005, d);
        `CHK("programmed", 8'h00, d)
        op(19'h7FFFF, 8'h20, 8'hD0);
        u_fpes_host.wr(19'h00000, 8'hFF);
        u_fpes_host.rd(19'h00000, d);
        `CHK("busy flag", 1'b0, d[7])
        waitr();
        rs(8'h80);
        u_fpes_host.wr(19'h00000, 8'hFF);
        u_fpes_host.rd(19'h70005, d);
        `CHK("erased low", 8'hFF, d)
        u_fpes_host.rd(19'h7A000, d);
        `CHK("erased high", 8'hFF, d)
        u_fpes_host.rd(19'h20005, d);
        `CHK("setup sector kept", 8'h00, d)
        op(19'h76000, 8'h40, 8'h00);
        waitr();
        op(19'h75FFF, 8'h40, 8'h00);
        waitr();
        op(19'h74000, 8'h21, 8'hD0);
        waitr();
        u_fpes_host.wr(19'h00000, 8'hFF);
        u_fpes_host.rd(19'h75FFF, d);
        `CHK("sub erased", 8'hFF, d)
        u_fpes_host.rd(19'h76000, d);
        `CHK("sub kept", 8'h00, d)
        sel = 1'b0;
        u_fpes_host.rd(19'h00000, d);
        `CHK("hub float", ~u_fpes_host.dout, d)
        `CHK("hub enable", 8'hFF, qoe_n)
        close_out();
    end
endmodule // fpes_seq_tb_top
`default_nettype wire
